// ===== shared/rcss_pkg.sv
/*
 * rcss_pkg: constants and types for the reset and clock source select block.
 * Assumes a single 50 MHz system clock; every slower rate is an enable pulse.
 */
package rcss_pkg;

	// system clock
	localparam int unsigned SYS_CLK_HZ      = 50000000;

	// internal oscillator emulated as a divider of the system clock
	localparam int unsigned INT_OSC_DIV     = 4;
	localparam int unsigned INT_OSC_CNT_W   = 2;
	localparam logic [1:0]  INT_OSC_LAST    = 2'(INT_OSC_DIV - 1);

	// step interval counter
	localparam int unsigned STEP_CNT_W      = 20;
	localparam logic [19:0] STEP_CNT_MAX    = 20'hFFFFF;
	localparam logic [19:0] STEP_CNT_RST    = 20'hFFFFF;

	// calibration step rate
	localparam int unsigned CAL_STEP_HZ     = 1000;

	// configuration fields and their power-up defaults
	localparam int unsigned OFF_TIME_W      = 4;
	localparam int unsigned PWM_FREQUENCY_SELECT_W      = 2;
	localparam logic [3:0]  OFF_TIME_RST    = 4'h0;
	localparam logic [1:0]  PWM_FREQUENCY_SELECT_RST    = 2'h1;

	typedef struct packed {
		logic [OFF_TIME_W-1:0] off_time_setting;
		logic [PWM_FREQUENCY_SELECT_W-1:0] pwm_frequency_select;
	} rcss_cfg_s;

	localparam rcss_cfg_s CFG_RST = '{
		off_time_setting:     OFF_TIME_RST,
		pwm_frequency_select: PWM_FREQUENCY_SELECT_RST
	};

	// monitored supply rails, high means below the undervoltage threshold
	typedef struct packed {
		logic analog_supply_rail;
		logic regulator_output_rail;
		logic io_supply_rail;
	} rcss_uv_s;

	typedef enum logic [0:0] {
		RCSS_SRC_INT,
		RCSS_SRC_EXT
	} rcss_src_e;

endpackage

// ===== logic/rcss_rise.sv
/*
 * rcss_rise: rising edge detector for a synchronous level.
 * Assumes the input is already synchronous to sys_clk_i.
 */
`timescale 1ns/10ps
module rcss_rise
(
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	// level in, pulse out
	input  wire logic level_i,
	output logic      rise_o
);

	logic prev;
	logic next_prev;

	always_comb
	begin
		next_prev = level_i;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prev <= 1'b0;
		else
			prev <= next_prev;
	end

	// reset holds prev low, so a pin already high at release gives one pulse
	assign rise_o = level_i & ~prev;

endmodule

// ===== logic/rcss_top.sv
/*
 * rcss_top: power-on and undervoltage reset of the configuration, device
 * clock source selection (internal divider or external clock pin), step
 * interval measurement for oscillator calibration, and system-clocked short to
 * ground reporting.
 * Assumes all pins are synchronous to sys_clk_i and that the undervoltage
 * flags come from analog comparators outside this block.
 */
`timescale 1ns/10ps
module rcss_top
(
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rstn_i,
	// supply monitors
	input  wire rcss_pkg::rcss_uv_s    uv_i,
	// clock pin and step input
	input  wire logic                  ext_clk_pin_i,
	input  wire logic                  step_i,
	// configuration writes from the serial side
	input  wire logic                  cfg_wr_i,
	input  wire rcss_pkg::rcss_cfg_s   cfg_wdata_i,
	// short to ground detection
	input  wire logic                  s2g_enable_i,
	input  wire logic                  s2g_fault_i,
	// outputs
	output logic                       cfg_reset_o,
	output rcss_pkg::rcss_cfg_s        cfg_o,
	output logic                       driver_en_o,
	output logic                       dev_clk_tick_o,
	output logic                       ext_clk_sel_o,
	output logic [19:0]                step_interval_measure_o,
	output logic                       step_interval_valid_o,
	output logic                       s2g_detect_o
);

	logic               uv_any;
	logic               ext_rise;
	logic               step_rise;

	rcss_pkg::rcss_src_e src;
	rcss_pkg::rcss_src_e next_src;
	logic [1:0]         osc_cnt;
	logic [1:0]         next_osc_cnt;
	logic               tick;
	logic               next_tick;

	rcss_pkg::rcss_cfg_s cfg;
	rcss_pkg::rcss_cfg_s next_cfg;
	logic               cfg_reset;
	logic               next_cfg_reset;
	logic               driver_en;
	logic               next_driver_en;

	logic [19:0]        step_cnt;
	logic [19:0]        next_step_cnt;
	logic [19:0]        step_meas;
	logic [19:0]        next_step_meas;
	logic               step_valid;
	logic               next_step_valid;
	logic               s2g;
	logic               next_s2g;

	// core supply has no monitor; only these three rails reset the block
	assign uv_any = uv_i.analog_supply_rail | uv_i.regulator_output_rail
		| uv_i.io_supply_rail;

	rcss_rise u_ext_rise
	(
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.level_i   (ext_clk_pin_i),
		.rise_o    (ext_rise)
	);

	rcss_rise u_step_rise
	(
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.level_i   (step_i),
		.rise_o    (step_rise)
	);

	// clock source and device clock tick
	always_comb
	begin
		next_src     = src;
		next_osc_cnt = osc_cnt;
		next_tick    = 1'b0;
		if (uv_any)
		begin
			next_src     = rcss_pkg::RCSS_SRC_INT;
			next_osc_cnt = '0;
		end
		else
		begin
			case (src)
				rcss_pkg::RCSS_SRC_INT:
				begin
					if (ext_clk_pin_i)
					begin
						// no internal tick in the switch cycle, so no runt period
						next_src     = rcss_pkg::RCSS_SRC_EXT;
						next_osc_cnt = '0;
						next_tick    = ext_rise;
					end
					else
					begin
						next_osc_cnt = (osc_cnt == rcss_pkg::INT_OSC_LAST) ? '0
							: osc_cnt + 2'h1;
						next_tick    = (osc_cnt == rcss_pkg::INT_OSC_LAST);
					end
				end
				rcss_pkg::RCSS_SRC_EXT:
				begin
					// latched: a stopped external clock also stops the ticks
					next_tick = ext_rise;
				end
				default:
				begin
					next_src = rcss_pkg::RCSS_SRC_INT;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			src     <= rcss_pkg::RCSS_SRC_INT;
			osc_cnt <= '0;
			tick    <= 1'b0;
		end
		else
		begin
			src     <= next_src;
			osc_cnt <= next_osc_cnt;
			tick    <= next_tick;
		end
	end

	// configuration with power-up defaults
	always_comb
	begin
		next_cfg       = cfg;
		next_cfg_reset = uv_any;
		if (uv_any)
			next_cfg = rcss_pkg::CFG_RST;
		else if (cfg_wr_i)
			next_cfg = cfg_wdata_i;
		// zero off-time is the documented way software parks the driver
		next_driver_en = (next_cfg.off_time_setting != '0) && !uv_any;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cfg       <= rcss_pkg::CFG_RST;
			cfg_reset <= 1'b1;
			driver_en <= 1'b0;
		end
		else
		begin
			cfg       <= next_cfg;
			cfg_reset <= next_cfg_reset;
			driver_en <= next_driver_en;
		end
	end

	// step interval in device clock ticks; 1 kHz steps give ticks per ms
	always_comb
	begin
		next_step_cnt   = step_cnt;
		next_step_meas  = step_meas;
		next_step_valid = step_valid;
		if (uv_any)
		begin
			next_step_cnt   = '0;
			next_step_meas  = rcss_pkg::STEP_CNT_RST;
			next_step_valid = 1'b0;
		end
		else
		begin
			if (tick && step_cnt != rcss_pkg::STEP_CNT_MAX)
				next_step_cnt = step_cnt + 20'h00001;
			if (step_rise)
			begin
				// the tick in the step cycle closes this interval, the next starts at zero
				next_step_meas  = next_step_cnt;
				next_step_cnt   = '0;
				next_step_valid = step_valid | (step_cnt != '0) | tick;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			step_cnt   <= '0;
			step_meas  <= rcss_pkg::STEP_CNT_RST;
			step_valid <= 1'b0;
		end
		else
		begin
			step_cnt   <= next_step_cnt;
			step_meas  <= next_step_meas;
			step_valid <= next_step_valid;
		end
	end

	// short to ground runs on the system clock, not on the device tick
	always_comb
	begin
		next_s2g = s2g_enable_i & s2g_fault_i;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			s2g <= 1'b0;
		else
			s2g <= next_s2g;
	end

	assign cfg_reset_o             = cfg_reset;
	assign cfg_o                   = cfg;
	assign driver_en_o             = driver_en;
	assign dev_clk_tick_o          = tick;
	assign ext_clk_sel_o           = (src == rcss_pkg::RCSS_SRC_EXT);
	assign step_interval_measure_o = step_meas;
	assign step_interval_valid_o   = step_valid;
	assign s2g_detect_o            = s2g;

endmodule

// ===== dv/rcss_asserts.sv
/* rcss_asserts: port checker for rcss_top.
 assumes binding to every rcss_top instance. */
`timescale 1ns/10ps
module rcss_asserts
(
	// clock, reset and inputs
	input wire logic                sys_clk_i,
	input wire logic                rstn_i,
	input wire rcss_pkg::rcss_uv_s  uv_i,
	input wire logic                ext_clk_pin_i,
	input wire logic                s2g_enable_i,
	input wire logic                s2g_fault_i,
	// outputs
	input wire logic                cfg_reset_o,
	input wire rcss_pkg::rcss_cfg_s cfg_o,
	input wire logic                driver_en_o,
	input wire logic                dev_clk_tick_o,
	input wire logic                ext_clk_sel_o,
	input wire logic                s2g_detect_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	a_uv_defaults: assert property (|uv_i |=> cfg_o == rcss_pkg::CFG_RST && !driver_en_o)
		else $error("defaults not restored");
	a_uv_flag: assert property (|uv_i |=> cfg_reset_o)
		else $error("reset flag missing");
	a_int_tick: assert property (dev_clk_tick_o && !ext_clk_sel_o && !ext_clk_pin_i
		&& !(|uv_i) |=> !dev_clk_tick_o)
		else $error("internal ticks too close");
	a_int_period: assert property (dev_clk_tick_o && !ext_clk_sel_o && !ext_clk_pin_i
		&& !(|uv_i) ##1 (!ext_clk_pin_i && !(|uv_i))[*3] |=> dev_clk_tick_o)
		else $error("internal tick period wrong");
	a_ext_select: assert property (ext_clk_pin_i && !(|uv_i) |=> ext_clk_sel_o)
		else $error("external clock not selected");
	a_int_hold: assert property (!ext_clk_pin_i && !ext_clk_sel_o |=> !ext_clk_sel_o)
		else $error("selected without pin high");
	a_ext_tick: assert property ($rose(ext_clk_pin_i) && !(|uv_i) |=> dev_clk_tick_o)
		else $error("tick missing after pin rise");
	a_ext_quiet: assert property (ext_clk_sel_o && !$rose(ext_clk_pin_i) |=> !dev_clk_tick_o)
		else $error("tick without pin rise");
	a_s2g_follow: assert property (1'b1 |=> s2g_detect_o == $past(s2g_enable_i && s2g_fault_i))
		else $error("short detect wrong");
endmodule

bind rcss_top rcss_asserts rcss_asserts_inst
(
	.sys_clk_i, .rstn_i, .uv_i, .ext_clk_pin_i, .s2g_enable_i, .s2g_fault_i,
	.cfg_reset_o, .cfg_o, .driver_en_o, .dev_clk_tick_o, .ext_clk_sel_o, .s2g_detect_o
);

// ===== dv/rcss_clk_src.sv
/* rcss_clk_src: external clock source beside the host.
 assumes run_i changes away from the rising edge. */
`timescale 1ns/10ps
module rcss_clk_src
(
	// clock and enable
	input  wire logic sys_clk_i,
	input  wire logic run_i,
	// clock pin
	output logic      pin_o
);
	logic [2:0] ph;

	// 10 MHz, two high of five; duty only matters near 18 MHz
	always @(posedge sys_clk_i)
	begin
		ph <= (ph == 3'h4 || !run_i) ? 3'h0 : ph + 3'h1;
		pin_o <= run_i && ph < 3'h2;
	end

	initial
	begin
		ph = 3'h0;
		pin_o = 1'b0;
	end
endmodule

// ===== dv/tb_top.sv
/* tb_top: self-checking bench for rcss_top.
 assumes the design samples every pin on the rising edge. */
`timescale 1ns/10ps
module tb_top;
	logic                sys_clk_i, rstn_i, step_i, cfg_wr_i, s2g_enable_i, s2g_fault_i;
	logic                ext_clk_pin_i, ext_run, cfg_reset_o, driver_en_o, dev_clk_tick_o;
	logic                ext_clk_sel_o, step_interval_valid_o, s2g_detect_o;
	logic [19:0]         step_interval_measure_o;
	rcss_pkg::rcss_uv_s  uv_i;
	rcss_pkg::rcss_cfg_s cfg_wdata_i, cfg_o;
	int                  error_cnt, total_checks;

	rcss_top rcss_top_inst
	(
		.sys_clk_i, .rstn_i, .uv_i, .ext_clk_pin_i, .step_i, .cfg_wr_i, .cfg_wdata_i,
		.s2g_enable_i, .s2g_fault_i, .cfg_reset_o, .cfg_o, .driver_en_o, .dev_clk_tick_o,
		.ext_clk_sel_o, .step_interval_measure_o, .step_interval_valid_o, .s2g_detect_o
	);
	rcss_clk_src rcss_clk_src_inst (.sys_clk_i, .run_i(ext_run), .pin_o(ext_clk_pin_i));

	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	task automatic wr(input rcss_pkg::rcss_cfg_s d);
		@(negedge sys_clk_i);
		cfg_wr_i = 1'b1;
		cfg_wdata_i = d;
		@(negedge sys_clk_i);
		cfg_wr_i = 1'b0;
	endtask

	task automatic ticks(input int n, input logic [19:0] exp);
		logic [19:0] c;
		c = 20'h0;
		repeat (n)
		begin
			@(negedge sys_clk_i);
			c = c + 20'(dev_clk_tick_o);
		end
		chk(c, exp);
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic t_reset;
		chk(20'(cfg_o), 20'(rcss_pkg::CFG_RST));
		chk(20'(driver_en_o), 20'h0);
		ticks(40, 20'hA);
		chk(20'(ext_clk_sel_o), 20'h0);
	endtask

	task automatic t_uv;
		for (int i = 0; i < 3; i++)
		begin
			wr('{4'h5, 2'h2});
			chk(20'(cfg_o), 20'h16);
			chk(20'(driver_en_o), 20'h1);
			cyc(1);
			uv_i = 3'(1 << i);
			// analog rail low is the host hard reset: no config write is driven then
			cfg_wr_i = (i != 2);
			cfg_wdata_i = '{4'h7, 2'h3};
			cyc(1);
			chk(20'(cfg_reset_o), 20'h1);
			uv_i = 3'h0;
			cfg_wr_i = 1'b0;
			cyc(1);
			chk(20'(cfg_reset_o), 20'h0);
			chk(20'(cfg_o), 20'(rcss_pkg::CFG_RST));
			chk(20'(driver_en_o), 20'h0);
		end
		wr('{4'h0, 2'h1});
	endtask

	// 400-cycle steps stand in for 1 kHz to keep the run short
	task automatic t_step;
		repeat (3)
		begin
			step_i = 1'b1;
			cyc(2);
			step_i = 1'b0;
			cyc(398);
		end
		chk(step_interval_measure_o, 20'h64);
		chk(20'(step_interval_valid_o), 20'h1);
	endtask

	task automatic t_ext;
		wr('{4'h0, 2'h1});
		ext_run = 1'b1;
		cyc(3);
		chk(20'(ext_clk_sel_o), 20'h1);
		ticks(40, 20'h8);
		ext_run = 1'b0;
		cyc(2);
		ticks(40, 20'h0);
		chk(20'(ext_clk_sel_o), 20'h1);
		s2g_enable_i = 1'b1;
		s2g_fault_i = 1'b1;
		cyc(2);
		chk(20'(s2g_detect_o), 20'h1);
		s2g_fault_i = 1'b0;
		cyc(2);
		chk(20'(s2g_detect_o), 20'h0);
		s2g_enable_i = 1'b0;
		s2g_fault_i = 1'b1;
		cyc(2);
		chk(20'(s2g_detect_o), 20'h0);
	endtask

	initial
	begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	initial
	begin
		rstn_i = 1'b0;
		uv_i = 3'h0;
		step_i = 1'b0;
		cfg_wr_i = 1'b0;
		cfg_wdata_i = rcss_pkg::CFG_RST;
		s2g_enable_i = 1'b0;
		s2g_fault_i = 1'b0;
		ext_run = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		cyc(8);
		chk(20'(cfg_reset_o), 20'h1);
		rstn_i = 1'b1;
		cyc(2);
		t_reset;
		t_uv;
		t_step;
		t_ext;
		wrap_up;
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		error_cnt++;
		wrap_up;
	end
endmodule
